// file: inc/sec_defs.svh
// How it works
// (RULE_01) check code covers each aligned two-byte word as one unit
// (RULE_02) six check bits stored beside each 16-bit word, 22 bits per entry
// (RULE_03) a single flipped bit is located and corrected read data is returned
// (RULE_04) two wrong bits are flagged uncorrectable and never corrected
// (RULE_05) uncorrectable read raises an error strobe so the master drops the data
// (RULE_06) any normal write recomputes and stores fresh check bits; a byte write whose fetch shows a double error is not stored
// (RULE_07) byte writes merge with the other byte, then check bits are recomputed
// (RULE_08) single errors corrected on reads and byte-write fetches, then written back
// (RULE_09) debug path reads and writes raw data and check bits without coding
// (RULE_10) memory cleared after reset; ready bit 0 of status is 0 until done
// (RULE_11) writes to the status register are ignored
// (RULE_12) enable bit 0 gates the single-error interrupt onto the request line
// (RULE_13) enable register read/write anytime, bits 7..1 read zero, resets to zero
// (RULE_14) sticky single-error flag set on each correction until software clears it
// (RULE_15) extended Hamming code: unique syndrome per single error, distinct double
`ifndef SEC_DEFS_SVH
`define SEC_DEFS_SVH

`define SEC_DATA_W 16
`define SEC_CHK_W 6
`define SEC_PAR_N 5
`define SEC_CW_TOP 21
`define SEC_IDX_W 8
`define SEC_IDX_MAX 8'hFF
`define SEC_SRAM_SEL_BIT 12
`define SEC_IDX_LO 2
`define SEC_IDX_HI 9
`define SEC_REG_HI 4
`define SEC_REG_IDX_STATUS 3'h0
`define SEC_REG_IDX_IE 3'h1
`define SEC_REG_IDX_FLAGS 3'h2
`define SEC_REG_IDX_DBG_ADDR 3'h3
`define SEC_REG_IDX_DBG_DATA 3'h4
`define SEC_BIT_RDY 0
`define SEC_BIT_SINGLE_IE 0
`define SEC_BIT_SINGLE 0
`define SEC_BIT_DOUBLE 1
`define SEC_IE_RESET 8'h00
`define SEC_IE_MASK 8'h01
`define SEC_FLAGS_RESET 2'h0
`define SEC_HSIZE_BYTE 3'h0
`define SEC_HRESP_OKAY 1'b0

`endif

// file: inc/sec_pkg.sv
package sec_pkg;

  typedef struct packed {
    logic [5:0] check;
    logic [15:0] data;
  } sec_word_type;

  typedef struct packed {
    logic [15:0] data;
    logic single;
    logic double;
  } sec_dec_type;

  typedef enum logic {
    SEC_IDLE,
    SEC_DATA
  } sec_state_type;

endpackage : sec_pkg

// file: rtl/sec_codec.sv
`include "sec_defs.svh"

module sec_codec (
  input wire logic [15:0] enc_data,
  output logic [5:0] enc_check,
  input wire sec_pkg::sec_word_type dec_word,
  output sec_pkg::sec_dec_type dec_out
);

  // ****************************************
  // code word layout
  // ****************************************
  function automatic logic [21:0] build_cw(input logic [15:0] d, input logic [4:0] par);
    logic [21:0] cw;
    int k;
    int j;
    cw = '0;
    k = 0;
    j = 0;
    for (int p = 1; p <= `SEC_CW_TOP; p++) begin
      if ((p & (p - 1)) == 0) begin
        cw[p] = par[j];
        j++;
      end else begin
        cw[p] = d[k];
        k++;
      end
    end
    return cw;
  endfunction : build_cw

  function automatic logic [4:0] syndrome(input logic [21:0] cw);
    logic [4:0] s;
    s = '0;
    for (int i = 0; i < `SEC_PAR_N; i++) begin
      for (int p = 1; p <= `SEC_CW_TOP; p++) begin
        if ((p & (1 << i)) != 0) begin
          s[i] = s[i] ^ cw[p];
        end
      end
    end
    return s;
  endfunction : syndrome

  function automatic logic [15:0] extract(input logic [21:0] cw);
    logic [15:0] d;
    int k;
    d = '0;
    k = 0;
    for (int p = 1; p <= `SEC_CW_TOP; p++) begin
      if ((p & (p - 1)) != 0) begin
        d[k] = cw[p];
        k++;
      end
    end
    return d;
  endfunction : extract

  // ****************************************
  // encoder
  // ****************************************
  logic [4:0] enc_par;

  always_comb begin
    enc_par = syndrome(build_cw(enc_data, 5'h00)); // RULE_01
    enc_check = {(^enc_data) ^ (^enc_par), enc_par}; // RULE_15
  end

  // ****************************************
  // decoder
  // ****************************************
  logic [21:0] dec_cw;
  logic [4:0] dec_syn;
  logic dec_odd;

  always_comb begin
    dec_cw = build_cw(dec_word.data, dec_word.check[4:0]);
    dec_syn = syndrome(dec_cw);
    dec_odd = (^dec_cw) ^ dec_word.check[5];
    // an odd overall parity with a syndrome past the last position cannot be one bit
    dec_out.single = dec_odd && (dec_syn <= 5'(`SEC_CW_TOP)); // RULE_15
    dec_out.double = (!dec_odd && dec_syn != 5'h00) || (dec_odd && dec_syn > 5'(`SEC_CW_TOP)); // RULE_04
    if (dec_out.single && dec_syn != 5'h00) begin
      dec_cw[dec_syn] = ~dec_cw[dec_syn]; // RULE_03
    end
    dec_out.data = extract(dec_cw);
  end

endmodule : sec_codec

// file: rtl/sec_top.sv
// Design decision made here: register access over AHB-Lite.
`include "sec_defs.svh"

module sec_top (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  output logic uncorr_err
);

  // ****************************************
  // storage and state
  // ****************************************
  sec_pkg::sec_word_type mem [0:`SEC_IDX_MAX];
  sec_pkg::sec_word_type mem_q;
  sec_pkg::sec_state_type state;
  logic ready;
  logic [7:0] init_idx;
  logic [7:0] irq_enable;
  logic [1:0] flags;
  logic [7:0] dbg_addr;

  logic a_write;
  logic a_byte;
  logic a_lane;
  logic a_sram;
  logic [2:0] a_reg;
  logic [7:0] a_idx;

  // ****************************************
  // address phase decode
  // ****************************************
  logic accept;
  logic [7:0] rd_idx;

  always_comb begin
    accept = hsel && htrans[1] && hready && (state == sec_pkg::SEC_IDLE);
    rd_idx = haddr[`SEC_SRAM_SEL_BIT] ? haddr[`SEC_IDX_HI:`SEC_IDX_LO] : dbg_addr;
  end

  // ****************************************
  // coder
  // ****************************************
  logic [15:0] enc_data;
  logic [5:0] enc_check;
  sec_pkg::sec_dec_type dec;

  sec_codec u_codec (
    .enc_data(enc_data),
    .enc_check(enc_check),
    .dec_word(mem_q),
    .dec_out(dec)
  );

  // ****************************************
  // data phase
  // ****************************************
  logic in_data;
  logic sram_op;
  logic dbg_op;
  logic reg_wr;
  logic needs_fetch;
  logic [15:0] merged;
  logic single_ev;
  logic double_ev;
  logic mem_we;
  logic [7:0] mem_wa;
  sec_pkg::sec_word_type mem_wd;
  logic [31:0] next_rdata;

  always_comb begin
    in_data = (state == sec_pkg::SEC_DATA);
    // memory is closed to the bus while it is being cleared
    sram_op = in_data && a_sram && ready; // RULE_10
    // debug access bypasses the coder and sets no flags
    dbg_op = in_data && !a_sram && ready && (a_reg == `SEC_REG_IDX_DBG_DATA);
    reg_wr = in_data && !a_sram && a_write;
    // halfword writes replace the whole word, so they never fetch or raise flags
    needs_fetch = !a_write || a_byte;
    merged = hwdata[15:0]; // RULE_06
    if (a_byte) begin
      if (a_lane) begin
        merged = {hwdata[15:8], dec.data[7:0]}; // RULE_07
      end else begin
        merged = {dec.data[15:8], hwdata[7:0]}; // RULE_07
      end
    end
    if (!ready) begin
      enc_data = 16'h0000;
    end else if (a_write) begin
      enc_data = merged;
    end else begin
      enc_data = dec.data;
    end
    single_ev = sram_op && needs_fetch && dec.single; // RULE_14
    double_ev = sram_op && needs_fetch && dec.double; // RULE_04
  end

  // ****************************************
  // memory write port
  // ****************************************
  always_comb begin
    mem_we = 1'b0;
    mem_wa = a_idx;
    mem_wd = {enc_check, enc_data}; // RULE_02
    if (!ready) begin
      mem_we = 1'b1; // RULE_10
      mem_wa = init_idx;
    end else if (dbg_op && a_write) begin
      mem_we = 1'b1;
      mem_wd = hwdata[21:0]; // RULE_09
    end else if (sram_op && a_write) begin
      // a fetch with two bad bits is left alone rather than hidden behind new check bits
      mem_we = !(a_byte && dec.double); // RULE_04
    end else if (sram_op && dec.single) begin
      mem_we = 1'b1; // RULE_08
    end
  end

  always_ff @(posedge sys_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    // read every cycle on the address-phase index, so a word written is seen next edge
    mem_q <= mem[rd_idx];
  end

  // ****************************************
  // read data
  // ****************************************
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (a_sram) begin
      if (ready) begin
        next_rdata = {16'h0000, dec.data}; // RULE_03
      end
    end else begin
      case (a_reg)
        `SEC_REG_IDX_STATUS: begin
          next_rdata[`SEC_BIT_RDY] = ready; // RULE_10
        end
        `SEC_REG_IDX_IE: begin
          next_rdata[7:0] = irq_enable; // RULE_13
        end
        `SEC_REG_IDX_FLAGS: begin
          next_rdata[1:0] = flags;
        end
        `SEC_REG_IDX_DBG_ADDR: begin
          next_rdata[7:0] = dbg_addr;
        end
        `SEC_REG_IDX_DBG_DATA: begin
          if (ready) begin
            next_rdata[21:0] = mem_q; // RULE_09
          end
        end
        default: begin
          next_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ****************************************
  // bus handshake
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state <= sec_pkg::SEC_IDLE;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      a_write <= 1'b0;
      a_byte <= 1'b0;
      a_lane <= 1'b0;
      a_sram <= 1'b0;
      a_reg <= 3'h0;
      a_idx <= 8'h00;
    end else begin
      case (state)
        sec_pkg::SEC_IDLE: begin
          if (accept) begin
            a_write <= hwrite;
            a_byte <= (hsize == `SEC_HSIZE_BYTE);
            a_lane <= haddr[0];
            a_sram <= haddr[`SEC_SRAM_SEL_BIT];
            a_reg <= haddr[`SEC_REG_HI:`SEC_IDX_LO];
            a_idx <= rd_idx;
            // one wait state per access gives fetch, fix and write-back a whole cycle
            hreadyout <= 1'b0;
            state <= sec_pkg::SEC_DATA;
          end
        end
        sec_pkg::SEC_DATA: begin
          // writes return zero so no stale word leaks onto the bus
          hrdata <= a_write ? 32'h0000_0000 : next_rdata;
          hreadyout <= 1'b1;
          state <= sec_pkg::SEC_IDLE;
        end
        default: begin
          state <= sec_pkg::SEC_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      hresp <= `SEC_HRESP_OKAY;
    end else begin
      hresp <= `SEC_HRESP_OKAY;
    end
  end

  // strobe stands in the very cycle that the read data completes
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      uncorr_err <= 1'b0;
    end else begin
      uncorr_err <= double_ev && !a_write; // RULE_05
    end
  end

  // ****************************************
  // memory clearing
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      ready <= 1'b0;
      init_idx <= 8'h00;
    end else if (!ready) begin
      // clearing stores data 0 with check 0, itself a valid code word
      init_idx <= init_idx + 8'h01; // RULE_10
      if (init_idx == `SEC_IDX_MAX) begin
        ready <= 1'b1; // RULE_10
      end
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      irq_enable <= `SEC_IE_RESET; // RULE_13
    end else if (reg_wr && a_reg == `SEC_REG_IDX_IE) begin
      irq_enable <= hwdata[7:0] & `SEC_IE_MASK; // RULE_13
    end
  end

  // the status index has no write branch anywhere, so its writes fall away
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      dbg_addr <= 8'h00;
    end else if (reg_wr && a_reg == `SEC_REG_IDX_DBG_ADDR) begin
      dbg_addr <= hwdata[7:0]; // RULE_11
    end
  end

  // ****************************************
  // event flags and interrupt
  // ****************************************
  logic [1:0] flag_clr;
  logic [1:0] flag_set;

  always_comb begin
    flag_clr = 2'h0;
    if (reg_wr && a_reg == `SEC_REG_IDX_FLAGS) begin
      flag_clr = hwdata[1:0];
    end
    flag_set = 2'h0;
    flag_set[`SEC_BIT_SINGLE] = single_ev;
    flag_set[`SEC_BIT_DOUBLE] = double_ev;
  end

  // a set in the same cycle as its clear wins, so no event is lost
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      flags <= `SEC_FLAGS_RESET;
    end else begin
      flags <= (flags & ~flag_clr) | flag_set; // RULE_14
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      // only single errors reach the request line; double errors stay in the flags
      irq <= flags[`SEC_BIT_SINGLE] && irq_enable[`SEC_BIT_SINGLE_IE]; // RULE_12
    end
  end

endmodule : sec_top

// file: verification/sec_top_asserts.sv
// ****
// bus timing and error signalling
// ****
module sec_top_chk (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic irq,
  input wire logic uncorr_err
);
  timeunit 1ns;
  timeprecision 1ns;
  logic take;
  logic rd_mem;
  assign take = hsel && htrans[1] && hready;
  assign rd_mem = !hwrite && haddr[12];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence data_phase_s;
    !hreadyout ##1 hreadyout;
  endsequence
  one_wait_a: assert property (take && hreadyout |=> data_phase_s)
    else $error("no single wait state");
  wait_cause_a: assert property ($fell(hreadyout) |-> $past(take))
    else $error("wait without transfer");
  err_read_a: assert property (uncorr_err |-> $past(rd_mem, 2))
    else $error("error pulse not on memory read");
  err_pulse_a: assert property (uncorr_err |=> !uncorr_err)
    else $error("error pulse too long");
  err_phase_a: assert property (uncorr_err |-> hreadyout && !$past(hreadyout))
    else $error("error pulse off the data cycle");
  irq_cause_a: assert property ($changed(irq) |-> !$past(hreadyout, 2))
    else $error("irq moved without access");
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  rdata_hold_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data moved at rest");
endmodule : sec_top_chk

bind sec_top sec_top_chk i_chk (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .uncorr_err(uncorr_err));

// file: verification/sec_bus_master.sv
// ****
// single-transfer bus master
// ****
module sec_bus_master (
  input wire logic sys_clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic uncorr_err,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  task automatic wait_rdy(inout logic to);
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hready !== 1'b1 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    to = to | (n >= 50);
  endtask : wait_rdy
  // gap gives prompt and slow pacing; released haddr, hwrite and hwdata carry junk so their stale values never pass
  task automatic xfer(input logic w, input logic [31:0] a, input logic [2:0] sz,
    input logic [31:0] wd, input int gap, output logic [31:0] rd, output logic ue,
    output logic to);
    to = 1'b0;
    repeat (gap) @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= sz;
    wait_rdy(to);
    htrans <= 2'h0;
    haddr <= ~a;
    hwrite <= ~w;
    hwdata <= wd;
    wait_rdy(to);
    rd = hrdata;
    ue = uncorr_err;
    hwdata <= ~wd;
  endtask : xfer
endmodule : sec_bus_master

// file: verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ****
  // bench
  // ****
  localparam logic [31:0] R_IE = 32'h00000004;
  localparam logic [31:0] R_FLG = 32'h00000008;
  localparam logic [31:0] R_DA = 32'h0000000C;
  localparam logic [31:0] R_DD = 32'h00000010;
  localparam logic [31:0] MEM = 32'h00001000;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, irq, uncorr_err, ue, to;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, r, ma;
  logic [31:0] seed = 32'h00000004;
  logic [15:0] d;
  logic [21:0] raw;
  int fails = 0;
  int cmp_count = 0;
  always #25 sys_clk = ~sys_clk;
  sec_top i_dut (.sys_clk(sys_clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .uncorr_err(uncorr_err));
  sec_bus_master i_mst (.sys_clk(sys_clk), .hready(hreadyout), .hrdata(hrdata),
    .uncorr_err(uncorr_err), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // reference coder: data at non-power positions 1..21, overall parity on top
  function automatic logic [21:0] enc(input logic [15:0] v);
    logic [21:1] c;
    logic [5:0] p;
    int k;
    c = '0;
    p = '0;
    k = 0;
    for (int i = 1; i < 22; i++) begin
      if ((i & (i - 1)) != 0) begin
        c[i] = v[k];
        k++;
      end
    end
    for (int i = 1; i < 22; i++) begin
      for (int j = 0; j < 5; j++) begin
        if (i[j]) begin
          p[j] ^= c[i];
        end
      end
    end
    p[5] = ^{p[4:0], v};
    return {p, v};
  endfunction : enc
  task automatic end_sim;
    if (fails == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, input logic [2:0] s,
    input logic [31:0] v);
    i_mst.xfer(w, a, s, v, int'(xs() % 3), rd, ue, to);
    if (to === 1'b1) begin
      fails++;
      $display("[FAIL] %0t bus hang", $time);
      end_sim();
    end
  endtask : bus
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    bus(1'b1, a, 3'h2, v);
  endtask : wr
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e, input string m);
    bus(1'b0, a, 3'h2, 32'h0);
    chk(rd, e, m);
  endtask : rd_chk
  // corrupt word r[23:16] through the raw path after a clean write of d
  task automatic inject(input logic [21:0] flip);
    ma = MEM + {22'h0, r[23:16], 2'b00};
    d = r[15:0];
    raw = enc(d) ^ flip;
    wr(ma, r);
    wr(R_DA, {24'h0, r[23:16]});
    wr(R_DD, {10'h0, raw});
  endtask : inject
  initial begin
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    rd_chk(32'h0, 32'h0, "ready early");
    rd_chk(R_IE, 32'h0, "ie reset");
    wr(R_IE, 32'hFFFFFFFF);
    rd_chk(R_IE, 32'h1, "ie bits");
    wr(32'h0000001C, 32'hFFFFFFFF);
    rd_chk(32'h0000001C, 32'h0, "unmapped");
    wr(MEM + 32'h14, 32'h00001234);
    for (int n = 0; n < 200 && rd !== 32'h1; n++) begin
      bus(1'b0, 32'h0, 3'h2, 32'h0);
    end
    chk(rd, 32'h1, "ready");
    wr(32'h0, 32'h0);
    rd_chk(32'h0, 32'h1, "status write");
    rd_chk(MEM + 32'h14, 32'h0, "write during init");
    for (int k = 0; k < 22; k++) begin
      r = xs();
      wr(R_IE, {31'h0, r[24]});
      chk({31'h0, irq}, 32'h0, "irq idle");
      inject(22'h1 << k);
      rd_chk(ma, {16'h0, d}, "corrected");
      chk({31'h0, ue}, 32'h0, "false uncorr");
      rd_chk(R_DD, {10'h0, enc(d)}, "write back");
      rd_chk(R_FLG, 32'h1, "single flag");
      chk({31'h0, irq}, {31'h0, r[24]}, "irq gate");
      wr(R_FLG, 32'h1);
    end
    for (int k = 0; k < 6; k++) begin
      r = xs();
      inject(22'h3 << (r[28:24] % 21));
      bus(1'b0, ma, 3'h2, 32'h0);
      chk({31'h0, ue}, 32'h1, "uncorr");
      rd_chk(R_DD, {10'h0, raw}, "no fix");
      rd_chk(R_FLG, 32'h2, "double flag");
      rd_chk(R_DA, {24'h0, r[23:16]}, "debug index");
      bus(1'b1, ma, 3'h0, r);
      chk({31'h0, ue}, 32'h0, "pulse on write");
      rd_chk(R_DD, {10'h0, raw}, "byte on double");
      wr(R_FLG, 32'h3);
      wr(ma, r);
      rd_chk(R_DD, {10'h0, enc(d)}, "fresh check");
    end
    r = xs();
    inject(22'h8);
    bus(1'b1, ma | 32'h1, 3'h0, {16'h0, r[31:24], ~r[31:24]});
    rd_chk(ma, {16'h0, r[31:24], d[7:0]}, "byte hi");
    rd_chk(R_FLG, 32'h1, "fetch fix");
    bus(1'b1, ma, 3'h0, {16'h0, ~d[15:8], d[15:8]});
    rd_chk(R_DD, {10'h0, enc({r[31:24], d[15:8]})}, "byte lo");
    end_sim();
  end
endmodule : tb
